// *** design/scrm_regs.svh ***
// Register offsets, field positions and reset values for the serial channel config block
//
// Behaviour
// - Tx interrupt when buffer empties, if enabled
// - Ext/status master enable gates all sources
// - One shared vector; channel A reads raw
// - Channel B vector carries status, high/low
// - Rx length codes: 5,7,6,8 bits
// - Async pads ones; sync moves 8-bit slices
// - Auto enables: CTS/DCD gate tx/rx
// - Loopback ignores pins, echo only CTS; finish byte
// - Hunt on command, reset, abort, disable
// - Sync match clears hunt, raises ext event
// - Rx CRC enable; forced SDLC; ignored async
// - SDLC address search drops only the byte that mismatches
// - Load inhibit: compare upper nibble only
// - Sync strip: drop bytes matching tx sync
// - Six-bit monosync strips every sync; six-bit bisync ignores
// - Receiver enable starts rx; reset clears
// - Clock ratio 1/16/32/64; sync forces 1 unless ext
// - External sync: rate field selects source
// - Monosync: rx sync match, tx sync fill
// - Bisync: 16-bit concatenated sync, 12 or 16 compare
// - External sync from pin; crystal forces zero
// - Sync mode only when stop bits 00
`ifndef SCRM_REGS_SVH
`define SCRM_REGS_SVH
`define SCRM_OFF_INT_CTRL 12'h004
`define SCRM_OFF_VECTOR 12'h008
`define SCRM_OFF_RX_PARAM 12'h00C
`define SCRM_OFF_CLK_SYNC 12'h010
`define SCRM_OFF_TX_SYNC 12'h018
`define SCRM_OFF_RX_SYNC 12'h01C
`define SCRM_OFF_MASTER 12'h024
`define SCRM_OFF_MISC 12'h028
`define SCRM_OFF_CLKSRC 12'h02C
`define SCRM_OFF_EXT_EN 12'h03C
`define SCRM_OFF_LINE_ST 12'h040
`define SCRM_OFF_RX_BYTE 12'h044
`define SCRM_OFF_VEC_B 12'h048
`define SCRM_OFF_TX_STAT 12'h04C
`define SCRM_OFF_CMD 12'h050
`define SCRM_B_TXIE 1
`define SCRM_B_EXTIE 0
`define SCRM_B_AUTO 5
`define SCRM_B_HUNT 4
`define SCRM_B_RXCRC 3
`define SCRM_B_ADRS 2
`define SCRM_B_INH 1
`define SCRM_B_RXEN 0
`define SCRM_B_VIS 0
`define SCRM_B_SHSL 4
`define SCRM_B_SYNC6 0
`define SCRM_B_LOOP 0
`define SCRM_B_ECHO 1
`define SCRM_B_XTAL 7
`define SCRM_B_CMD_TXIP 0
`define SCRM_B_CMD_EXTCLR 1
`define SCRM_B_CMD_ABORT 2
`define SCRM_B_CMD_CHRST 3
`define SCRM_CLK_SYNC_RST 8'h04
`define SCRM_FLAG 8'h7E
`endif

// *** design/scrm_pkg.sv ***
// Types for the serial channel config block
package scrm_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } scrm_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } scrm_apb_rsp_t;
  typedef enum logic [1:0] {
    SCRM_SYNC_MONO = 2'b00,
    SCRM_SYNC_BI = 2'b01,
    SCRM_SYNC_SDLC = 2'b10,
    SCRM_SYNC_EXT = 2'b11
  } scrm_sync_t;
  typedef enum logic [1:0] {
    SCRM_RX_HUNT = 2'b00,
    SCRM_RX_ADDR = 2'b01,
    SCRM_RX_DATA = 2'b10
  } scrm_rx_st_t;
endpackage : scrm_pkg

// *** design/scrm_channel.sv ***
// Serial channel receive, mode and interrupt configuration logic
`timescale 1ns/1ps
`default_nettype none
`include "scrm_regs.svh"
module scrm_channel (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // APB
  input wire scrm_pkg::scrm_apb_req_t apb_i,
  output scrm_pkg::scrm_apb_rsp_t apb_o,
  // Serial link
  input wire logic rx_clk_i,
  input wire logic rx_data_i,
  input wire logic carrier_detect_input_n_i,
  input wire logic cts_n_i,
  input wire logic sync_n_i,
  // Transmitter status feed
  input wire logic tx_buf_empty_i,
  input wire logic tx_byte_busy_i,
  input wire logic ext_event_i,
  // Outputs
  output logic tx_int_req_o,
  output logic ext_int_req_o,
  output logic tx_gate_o,
  output logic rx_gate_o,
  output logic [6:0] clk_ratio_o,
  output logic [15:0] tx_fill_o,
  output logic fifo_wr_o,
  output logic [7:0] fifo_data_o,
  output logic crc_en_o
);
  import scrm_pkg::*;

  logic [7:0] int_ctrl_r, vector_r, rx_param_r, clk_sync_r;
  logic [7:0] tx_sync_or_address_reg_r, rx_sync_or_flag_reg_r;
  logic [7:0] master_interrupt_ctrl_reg_r, misc_line_ctrl_reg_r;
  logic [7:0] clock_source_ctrl_reg_r, ext_source_enables_reg_r;
  logic hunt_r, hunt_cmd, abort_cmd, ext_clr, txip_clr, chan_rst;
  logic tx_ip_r, ext_ip_r, tx_empty_d_r;
  logic wr_acc;
  scrm_rx_st_t rx_st_r;

  function automatic logic [7:0] scrm_pad(input logic [7:0] d, input logic [1:0] len);
    case (len)
      2'b00: scrm_pad = {3'b111, d[7:3]};
      2'b01: scrm_pad = {1'b1, d[7:1]};
      2'b10: scrm_pad = {2'b11, d[7:2]};
      default: scrm_pad = d;
    endcase
  endfunction : scrm_pad

  // Mode decode
  logic is_sync, is_sdlc, ext_mode, loopback, echo, sync6;
  scrm_sync_t smode;
  assign smode = scrm_sync_t'(clk_sync_r[5:4]);
  // Stop bits 00 enables sync modes
  assign is_sync = (clk_sync_r[3:2] == 2'b00);
  assign ext_mode = is_sync && (smode == SCRM_SYNC_EXT);
  // Ext sync with code 11 is SDLC
  assign is_sdlc = is_sync && ((smode == SCRM_SYNC_SDLC) ||
                   (ext_mode && clk_sync_r[7:6] == 2'b11));
  assign loopback = misc_line_ctrl_reg_r[`SCRM_B_LOOP];
  assign echo = misc_line_ctrl_reg_r[`SCRM_B_ECHO];
  assign sync6 = misc_line_ctrl_reg_r[`SCRM_B_SYNC6];

  // APB slave, zero wait states
  assign wr_acc = apb_i.psel && apb_i.penable && apb_i.pwrite;
  assign apb_o.pready = 1'b1;
  assign apb_o.pslverr = 1'b0;
  assign hunt_cmd = wr_acc && apb_i.paddr == `SCRM_OFF_RX_PARAM && apb_i.pwdata[`SCRM_B_HUNT];
  assign txip_clr = wr_acc && apb_i.paddr == `SCRM_OFF_CMD && apb_i.pwdata[`SCRM_B_CMD_TXIP];
  assign ext_clr = wr_acc && apb_i.paddr == `SCRM_OFF_CMD && apb_i.pwdata[`SCRM_B_CMD_EXTCLR];
  assign abort_cmd = wr_acc && apb_i.paddr == `SCRM_OFF_CMD && apb_i.pwdata[`SCRM_B_CMD_ABORT];
  assign chan_rst = wr_acc && apb_i.paddr == `SCRM_OFF_CMD && apb_i.pwdata[`SCRM_B_CMD_CHRST];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || chan_rst) begin
      int_ctrl_r <= 8'h00;
      rx_param_r <= 8'h00;
      clk_sync_r <= `SCRM_CLK_SYNC_RST;
    end else if (wr_acc) begin
      if (apb_i.paddr == `SCRM_OFF_INT_CTRL) begin
        int_ctrl_r <= apb_i.pwdata[7:0];
      end else if (apb_i.paddr == `SCRM_OFF_RX_PARAM) begin
        // Hunt bit is a command, not stored
        rx_param_r <= {apb_i.pwdata[7:5], 1'b0, apb_i.pwdata[3:0]};
      end else if (apb_i.paddr == `SCRM_OFF_CLK_SYNC) begin
        clk_sync_r <= apb_i.pwdata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      vector_r <= 8'h00;
      tx_sync_or_address_reg_r <= 8'h00;
      rx_sync_or_flag_reg_r <= 8'h00;
      master_interrupt_ctrl_reg_r <= 8'h00;
      misc_line_ctrl_reg_r <= 8'h00;
      clock_source_ctrl_reg_r <= 8'h00;
      ext_source_enables_reg_r <= 8'h00;
    end else if (wr_acc) begin
      if (apb_i.paddr == `SCRM_OFF_VECTOR) begin
        vector_r <= apb_i.pwdata[7:0];
      end else if (apb_i.paddr == `SCRM_OFF_TX_SYNC) begin
        tx_sync_or_address_reg_r <= apb_i.pwdata[7:0];
      end else if (apb_i.paddr == `SCRM_OFF_RX_SYNC) begin
        // Host loads flag here for SDLC
        rx_sync_or_flag_reg_r <= apb_i.pwdata[7:0];
      end else if (apb_i.paddr == `SCRM_OFF_MASTER) begin
        master_interrupt_ctrl_reg_r <= apb_i.pwdata[7:0];
      end else if (apb_i.paddr == `SCRM_OFF_MISC) begin
        misc_line_ctrl_reg_r <= apb_i.pwdata[7:0];
      end else if (apb_i.paddr == `SCRM_OFF_CLKSRC) begin
        clock_source_ctrl_reg_r <= apb_i.pwdata[7:0];
      end else if (apb_i.paddr == `SCRM_OFF_EXT_EN) begin
        ext_source_enables_reg_r <= apb_i.pwdata[7:0];
      end
    end
  end

  // Pin synchronisers
  logic [4:0] pin_s1_r, pin_s2_r;
  logic rxclk_d_r;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      // Link clock idles low, so no false edge after reset
      pin_s1_r <= 5'h0F;
      pin_s2_r <= 5'h0F;
      rxclk_d_r <= 1'b0;
    end else begin
      pin_s1_r <= {rx_clk_i, rx_data_i, carrier_detect_input_n_i, cts_n_i, sync_n_i};
      pin_s2_r <= pin_s1_r;
      rxclk_d_r <= pin_s2_r[4];
    end
  end
  logic dcd, cts, sync_pin, rx_bit, rx_edge;
  assign rx_edge = pin_s2_r[4] && !rxclk_d_r;
  assign rx_bit = pin_s2_r[3];
  assign dcd = !pin_s2_r[2];
  assign cts = !pin_s2_r[1];
  // Crystal option forces internal sync low
  assign sync_pin = !pin_s2_r[0] && !clock_source_ctrl_reg_r[`SCRM_B_XTAL];

  // Auto enables gate tx and rx
  // Pins ignored in loopback; only CTS ignored in echo
  logic tx_ok, rx_en;
  assign tx_ok = !rx_param_r[`SCRM_B_AUTO] || cts || loopback || echo;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_gate_o <= 1'b0;
    end else begin
      // A byte in flight is finished
      tx_gate_o <= tx_ok || (tx_gate_o && tx_byte_busy_i);
    end
  end
  assign rx_en = rx_param_r[`SCRM_B_RXEN] &&
                 (!rx_param_r[`SCRM_B_AUTO] || dcd || loopback);
  assign rx_gate_o = rx_en;

  // Clock ratio, forced 1 in sync unless ext
  always_comb begin
    if (is_sync && !ext_mode) begin
      clk_ratio_o = 7'd1;
    end else begin
      case (clk_sync_r[7:6])
        2'b00: clk_ratio_o = 7'd1;
        2'b01: clk_ratio_o = 7'd16;
        2'b10: clk_ratio_o = 7'd32;
        default: clk_ratio_o = 7'd64;
      endcase
    end
  end

  // Monosync and ext send tx sync fill
  assign tx_fill_o = (smode == SCRM_SYNC_BI) ?
                     {rx_sync_or_flag_reg_r, tx_sync_or_address_reg_r} :
                     {tx_sync_or_address_reg_r, tx_sync_or_address_reg_r};

  // Receive shifter; bits arrive LSB first
  logic [15:0] shift_r;
  logic [3:0] bitcnt_r;
  logic last_sync_r;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      shift_r <= 16'hFFFF;
    end else if (rx_edge && rx_en) begin
      shift_r <= {rx_bit, shift_r[15:1]};
    end
  end

  // Sync match, per mode
  logic [15:0] nxt;
  logic sync_hit, byte_done, strip, adr_ok;
  assign nxt = {rx_bit, shift_r[15:1]};
  always_comb begin
    sync_hit = 1'b0;
    if (is_sdlc) begin
      sync_hit = (nxt[15:8] == rx_sync_or_flag_reg_r) ||
                 (ext_mode && sync_pin);
    end else if (smode == SCRM_SYNC_MONO || (ext_mode && clk_sync_r[7:6] == 2'b10)) begin
      if (sync6) begin
        sync_hit = nxt[15:10] == rx_sync_or_flag_reg_r[5:0];
      end else begin
        sync_hit = nxt[15:8] == rx_sync_or_flag_reg_r;
      end
      sync_hit = sync_hit || (ext_mode && sync_pin);
    end else if (smode == SCRM_SYNC_BI) begin
      // 12 or 16 bit receive compare
      if (sync6) begin
        sync_hit = nxt[15:4] == {rx_sync_or_flag_reg_r[5:0], tx_sync_or_address_reg_r[5:0]};
      end else begin
        sync_hit = nxt == {rx_sync_or_flag_reg_r, tx_sync_or_address_reg_r};
      end
    end else begin
      // Codes 00/01 use only the pin
      sync_hit = sync_pin;
    end
  end

  // Hunt on command, reset, abort, disable
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || chan_rst || hunt_cmd || abort_cmd || !rx_en) begin
      hunt_r <= is_sync;
    end else if (rx_edge && is_sync && hunt_r && sync_hit) begin
      hunt_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || hunt_r || !rx_en) begin
      bitcnt_r <= 4'd0;
      rx_st_r <= SCRM_RX_HUNT;
    end else if (byte_done) begin
      bitcnt_r <= 4'd0;
      rx_st_r <= (rx_st_r == SCRM_RX_HUNT && is_sdlc &&
                  rx_param_r[`SCRM_B_ADRS]) ? SCRM_RX_ADDR : SCRM_RX_DATA;
      if (rx_st_r == SCRM_RX_ADDR && !adr_ok) begin
        // Mismatch: back to SCRM_RX_HUNT state without a flag search; the next byte is written
        rx_st_r <= SCRM_RX_HUNT;
      end
    end else if (rx_edge) begin
      bitcnt_r <= bitcnt_r + 4'd1;
    end
  end

  logic [3:0] char_len;
  assign char_len = (is_sync || rx_param_r[7:6] == 2'b11) ? 4'd8 :
                    (rx_param_r[7:6] == 2'b00) ? 4'd5 :
                    (rx_param_r[7:6] == 2'b10) ? 4'd6 : 4'd7;
  assign byte_done = rx_edge && bitcnt_r == char_len - 4'd1;
  assign adr_ok = rx_param_r[`SCRM_B_INH] ?
                  nxt[15:12] == tx_sync_or_address_reg_r[7:4] :
                  nxt[15:8] == tx_sync_or_address_reg_r;
  // Six-bit monosync strips every sync; six-bit bisync ignores
  assign strip = is_sync && !is_sdlc && rx_param_r[`SCRM_B_INH] &&
                 !(sync6 && smode == SCRM_SYNC_BI) &&
                 nxt[15:8] == tx_sync_or_address_reg_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fifo_wr_o <= 1'b0;
      fifo_data_o <= 8'h00;
      crc_en_o <= 1'b0;
      last_sync_r <= 1'b0;
    end else begin
      fifo_wr_o <= 1'b0;
      if (byte_done && !(rx_st_r == SCRM_RX_ADDR && !adr_ok)) begin
        last_sync_r <= strip;
        if (!strip || (sync6 && last_sync_r && 1'b0)) begin
          fifo_wr_o <= 1'b1;
          // Async pads upper bits with ones
          fifo_data_o <= is_sync ? nxt[15:8] : scrm_pad(nxt[15:8], rx_param_r[7:6]);
          // CRC: forced in SDLC, off in async
          crc_en_o <= is_sdlc || (is_sync && rx_param_r[`SCRM_B_RXCRC]);
        end
      end
    end
  end

  // Tx interrupt on buffer going empty
  logic ext_src;
  assign ext_src = (rx_edge && is_sync && hunt_r && sync_hit) || ext_event_i;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_empty_d_r <= 1'b1;
      tx_ip_r <= 1'b0;
      ext_ip_r <= 1'b0;
    end else begin
      tx_empty_d_r <= tx_buf_empty_i;
      if (int_ctrl_r[`SCRM_B_TXIE] && tx_buf_empty_i && !tx_empty_d_r) begin
        tx_ip_r <= 1'b1;
      end else if (txip_clr) begin
        tx_ip_r <= 1'b0;
      end
      if (int_ctrl_r[`SCRM_B_EXTIE] && ext_src) begin
        ext_ip_r <= 1'b1;
      end else if (ext_clr) begin
        ext_ip_r <= 1'b0;
      end
    end
  end
  assign tx_int_req_o = tx_ip_r;
  assign ext_int_req_o = ext_ip_r;

  // Channel B vector status in high or low bits
  logic [2:0] vstat;
  logic [7:0] vec_b;
  assign vstat = tx_ip_r ? 3'b000 : (ext_ip_r ? 3'b101 : 3'b011);
  assign vec_b = master_interrupt_ctrl_reg_r[`SCRM_B_SHSL] ?
                 {vector_r[7], vstat[0], vstat[1], vstat[2], vector_r[3:0]} :
                 {vector_r[7:4], vstat, vector_r[0]};

  always_comb begin
    apb_o.prdata = 32'h0000_0000;
    if (apb_i.paddr == `SCRM_OFF_VECTOR) begin
      apb_o.prdata = {24'h000000, vector_r};
    end else if (apb_i.paddr == `SCRM_OFF_VEC_B) begin
      apb_o.prdata = {24'h000000, vec_b};
    end else if (apb_i.paddr == `SCRM_OFF_LINE_ST) begin
      apb_o.prdata = {26'h0, cts, hunt_r, dcd, ext_ip_r, tx_ip_r, tx_buf_empty_i};
    end else if (apb_i.paddr == `SCRM_OFF_RX_BYTE) begin
      apb_o.prdata = {24'h000000, fifo_data_o};
    end else if (apb_i.paddr == `SCRM_OFF_RX_PARAM) begin
      apb_o.prdata = {24'h000000, rx_param_r};
    end else if (apb_i.paddr == `SCRM_OFF_CLK_SYNC) begin
      apb_o.prdata = {24'h000000, clk_sync_r};
    end
  end
endmodule : scrm_channel
`default_nettype wire

// *** testbench/scrm_channel_properties.sv ***
// Checker for the serial channel configuration block
`timescale 1ns/1ps
`default_nettype none
`include "scrm_regs.svh"
module scrm_channel_properties (
  // Clock and bus
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire scrm_pkg::scrm_apb_req_t apb_i,
  input wire scrm_pkg::scrm_apb_rsp_t apb_o,
  // Channel
  input wire logic tx_buf_empty_i,
  input wire logic tx_int_req_o,
  input wire logic ext_int_req_o,
  input wire logic rx_gate_o,
  input wire logic [6:0] clk_ratio_o,
  input wire logic fifo_wr_o,
  input wire logic [7:0] fifo_data_o
);
  import scrm_pkg::*;
  logic wr;
  logic rd;
  logic [7:0] ic_r;
  logic [7:0] rp_r;
  logic [7:0] cs_r;
  logic [7:0] vec_r;
  logic [7:0] mst_r;
  logic [7:0] vm;
  logic [6:0] rt_exp;
  assign wr = apb_i.psel & apb_i.penable & apb_i.pwrite;
  assign rd = apb_i.psel & apb_i.penable & ~apb_i.pwrite;
  // Status-free bits of the channel B vector
  assign vm = mst_r[`SCRM_B_SHSL] ? 8'h8F : 8'hF1;
  assign rt_exp = (cs_r[7:6] == 2'b00) ? 7'h01 : (7'h01 << (3'd3 + cs_r[7:6]));
  // Shadow of the written registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ic_r <= 8'h00;
      rp_r <= 8'h00;
      cs_r <= `SCRM_CLK_SYNC_RST;
      vec_r <= 8'h00;
      mst_r <= 8'h00;
    end else if (wr) begin
      case (apb_i.paddr)
        `SCRM_OFF_INT_CTRL: ic_r <= apb_i.pwdata[7:0];
        `SCRM_OFF_RX_PARAM: rp_r <= apb_i.pwdata[7:0];
        `SCRM_OFF_CLK_SYNC: cs_r <= apb_i.pwdata[7:0];
        `SCRM_OFF_VECTOR: vec_r <= apb_i.pwdata[7:0];
        `SCRM_OFF_MASTER: mst_r <= apb_i.pwdata[7:0];
        `SCRM_OFF_CMD: begin
          if (apb_i.pwdata[`SCRM_B_CMD_CHRST]) begin
            ic_r <= 8'h00;
            rp_r <= 8'h00;
            cs_r <= `SCRM_CLK_SYNC_RST;
          end
        end
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  AST_TX_SET: assert property (
    $rose(tx_buf_empty_i) && ic_r[`SCRM_B_TXIE] |-> ##[1:2] tx_int_req_o)
    else $error("tx interrupt not raised on empty buffer");
  AST_TX_GATE: assert property (
    $rose(tx_int_req_o) |-> $past(ic_r[`SCRM_B_TXIE]))
    else $error("tx interrupt raised while disabled");
  AST_EXT_GATE: assert property (
    $rose(ext_int_req_o) |-> $past(ic_r[`SCRM_B_EXTIE]))
    else $error("ext interrupt raised while master enable off");
  AST_VEC_A: assert property (
    rd && apb_i.paddr == `SCRM_OFF_VECTOR |-> apb_o.prdata == {24'h0, vec_r})
    else $error("channel A vector differs from stored");
  AST_VEC_B: assert property (
    rd && apb_i.paddr == `SCRM_OFF_VEC_B |-> (apb_o.prdata[7:0] & vm) == (vec_r & vm))
    else $error("channel B vector status in wrong bits");
  AST_RATIO: assert property (
    cs_r[3:2] != 2'b00 |-> clk_ratio_o == rt_exp)
    else $error("clock ratio wrong for rate code");
  AST_SYNC_1X: assert property (
    cs_r[3:2] == 2'b00 && cs_r[5:4] != 2'b11 |-> clk_ratio_o == 7'h01)
    else $error("sync mode not forced to 1x");
  AST_RX_OFF: assert property (
    !rp_r[`SCRM_B_RXEN] |-> !rx_gate_o)
    else $error("receiver gated on while disabled");
  AST_RX_NOAUTO: assert property (
    rp_r[`SCRM_B_RXEN] && !rp_r[`SCRM_B_AUTO] |-> rx_gate_o)
    else $error("receiver off with auto enables clear");
  AST_ASYNC_PAD: assert property (
    fifo_wr_o && cs_r[3:2] != 2'b00 && rp_r[7:6] == 2'b00 |-> fifo_data_o[7:5] == 3'b111)
    else $error("async five-bit byte not padded with ones");
  AST_CHRST: assert property (
    wr && apb_i.paddr == `SCRM_OFF_CMD && apb_i.pwdata[3] |=> !rx_gate_o && clk_ratio_o == 7'h01)
    else $error("channel reset left receiver or ratio set");
endmodule : scrm_channel_properties
bind scrm_channel scrm_channel_properties u_props (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .apb_i(apb_i),
  .apb_o(apb_o),
  .tx_buf_empty_i(tx_buf_empty_i),
  .tx_int_req_o(tx_int_req_o),
  .ext_int_req_o(ext_int_req_o),
  .rx_gate_o(rx_gate_o),
  .clk_ratio_o(clk_ratio_o),
  .fifo_wr_o(fifo_wr_o),
  .fifo_data_o(fifo_data_o)
);
`default_nettype wire

// *** testbench/scrm_line_model.sv ***
// Remote station model driving the receive line and modem pins
`timescale 1ns/1ps
`default_nettype none
module scrm_line_model (
  // Line
  output logic rx_clk_o,
  output logic rx_data_o,
  output logic dcd_n_o,
  output logic cts_n_o,
  output logic sync_n_o
);
  initial begin
    rx_clk_o = 1'b0;
    rx_data_o = 1'b1;
    dcd_n_o = 1'b1;
    cts_n_o = 1'b1;
    sync_n_o = 1'b1;
  end
  // Clock runs only within a frame; LSB first
  task send(input logic [31:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rx_data_o = bits[i];
      #80;
      rx_clk_o = 1'b1;
      #80;
      rx_clk_o = 1'b0;
    end
    rx_data_o = 1'b1;
  endtask : send
  task pins(input logic dcd_n, input logic cts_n);
    dcd_n_o = dcd_n;
    cts_n_o = cts_n;
  endtask : pins
endmodule : scrm_line_model
`default_nettype wire

// *** testbench/scrm_channel_tb_top.sv ***
// Testbench for the serial channel configuration block
`timescale 1ns/1ps
`default_nettype none
`include "scrm_regs.svh"
module scrm_channel_tb_top;
  import scrm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  scrm_apb_req_t req = '0;
  scrm_apb_rsp_t rsp;
  logic empty = 1'b0;
  logic ev = 1'b0;
  logic rx_clk, rx_d, dcd_n, cts_n, sync_n;
  logic tx_int, ext_int, tx_gate, rx_gate, fwr, crc_en;
  logic [6:0] ratio;
  logic [15:0] fill;
  logic [7:0] fdata;
  logic [7:0] fq[$];
  logic [31:0] q;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  scrm_line_model LINE (.rx_clk_o(rx_clk), .rx_data_o(rx_d), .dcd_n_o(dcd_n),
    .cts_n_o(cts_n), .sync_n_o(sync_n));
  scrm_channel DUT (.sys_clk_i(clk), .rst_i(rst), .apb_i(req), .apb_o(rsp),
    .rx_clk_i(rx_clk), .rx_data_i(rx_d), .carrier_detect_input_n_i(dcd_n),
    .cts_n_i(cts_n), .sync_n_i(sync_n), .tx_buf_empty_i(empty), .tx_byte_busy_i(1'b0),
    .ext_event_i(ev), .tx_int_req_o(tx_int), .ext_int_req_o(ext_int), .tx_gate_o(tx_gate),
    .rx_gate_o(rx_gate), .clk_ratio_o(ratio), .tx_fill_o(fill), .fifo_wr_o(fwr),
    .fifo_data_o(fdata), .crc_en_o(crc_en));
  always @(posedge clk) begin
    if (fwr === 1'b1) fq.push_back(fdata);
  end
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      end_sim();
    end
  end
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    req <= '0;
    @(posedge clk);
  endtask : xfer
  task wr(input logic [11:0] a, input logic [7:0] d);
    xfer(a, 1'b1, {24'h0, d});
  endtask : wr
  task rd(input logic [11:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask : rd
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task pulse(input logic t);
    @(posedge clk);
    empty <= t;
    ev <= ~t;
    @(posedge clk);
    empty <= 1'b0;
    ev <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(`SCRM_OFF_CLK_SYNC);
    chk("clk_sync reset", 32'h4, q);
    wr(12'h0FC, 8'h55);
    rd(12'h0FC);
    chk("unmapped", 32'h0, q);
    wr(`SCRM_OFF_VECTOR, 8'hFF);
    rd(`SCRM_OFF_VECTOR);
    chk("vector A", 32'hFF, q);
    rd(`SCRM_OFF_VEC_B);
    chk("vector B low", 32'hF1, q & 32'hF1);
    wr(`SCRM_OFF_MASTER, 8'h10);
    rd(`SCRM_OFF_VEC_B);
    chk("vector B high", 32'h8F, q & 32'h8F);
    $display("test vector done");
    for (int r = 0; r < 4; r++) begin
      wr(`SCRM_OFF_CLK_SYNC, {r[1:0], 6'h04});
      chk("ratio", (r == 0) ? 32'd1 : 32'd1 << (r + 3), {25'h0, ratio});
    end
    wr(`SCRM_OFF_CLK_SYNC, 8'hC0);
    chk("sync ratio", 32'd1, {25'h0, ratio});
    $display("test ratio done");
    wr(`SCRM_OFF_INT_CTRL, 8'h02);
    pulse(1'b1);
    chk("tx int", 32'd1, {31'h0, tx_int});
    wr(`SCRM_OFF_CMD, 8'h01);
    wr(`SCRM_OFF_INT_CTRL, 8'h00);
    pulse(1'b1);
    chk("tx int off", 32'd0, {31'h0, tx_int});
    wr(`SCRM_OFF_EXT_EN, 8'hFF);
    pulse(1'b0);
    chk("ext int off", 32'd0, {31'h0, ext_int});
    wr(`SCRM_OFF_INT_CTRL, 8'h01);
    pulse(1'b0);
    chk("ext int", 32'd1, {31'h0, ext_int});
    wr(`SCRM_OFF_CMD, 8'h02);
    $display("test interrupts done");
    // Monosync with stripping of the transmit sync byte
    wr(`SCRM_OFF_TX_SYNC, 8'h16);
    wr(`SCRM_OFF_RX_SYNC, 8'h16);
    wr(`SCRM_OFF_CLK_SYNC, 8'h00);
    wr(`SCRM_OFF_RX_PARAM, 8'hC3);
    chk("mono fill", 32'h1616, {16'h0, fill});
    fq.delete();
    LINE.send({8'h0, 8'hA5, 8'h16, 8'h16}, 24);
    repeat (10) @(posedge clk);
    chk("mono count", 32'd1, fq.size());
    chk("mono byte", 32'hA5, (fq.size() > 0) ? {24'h0, fq[0]} : 32'hX);
    chk("sync ext int", 32'd1, {31'h0, ext_int});
    chk("mono crc off", 32'd0, {31'h0, crc_en});
    $display("test monosync done");
    wr(`SCRM_OFF_CMD, 8'h08);
    rd(`SCRM_OFF_CLK_SYNC);
    chk("chan reset", 32'h4, q);
    chk("rx gate reset", 32'd0, {31'h0, rx_gate});
    wr(`SCRM_OFF_RX_PARAM, 8'h01);
    fq.delete();
    // Receiver frames no start bit: five data bits only
    LINE.send({27'h0, 5'h0A}, 5);
    repeat (10) @(posedge clk);
    chk("async byte", 32'hEA, (fq.size() > 0) ? {24'h0, fq[0]} : 32'hX);
    $display("test async done");
    wr(`SCRM_OFF_RX_PARAM, 8'h21);
    repeat (4) @(posedge clk);
    chk("auto no carrier", 32'd0, {31'h0, rx_gate});
    chk("auto no cts", 32'd0, {31'h0, tx_gate});
    LINE.pins(1'b0, 1'b1);
    repeat (6) @(posedge clk);
    chk("auto carrier", 32'd1, {31'h0, rx_gate});
    $display("test auto done");
    end_sim();
  end
endmodule : scrm_channel_tb_top
`default_nettype wire
